// ==== shared/mrd_pkg.sv ====
package mrd_pkg;

  // Byte addresses of the registers, reading high byte at the base
  localparam logic [7:0] MRD_THERM_ADDR = 8'h3f;
  localparam logic [7:0] MRD_DIE_ADDR = 8'h41;
  localparam logic [7:0] MRD_DPLUS_ADDR = 8'h43;
  localparam logic [7:0] MRD_DMINUS_ADDR = 8'h45;
  localparam logic [7:0] MRD_DRIVE_ADDR = 8'h47;
  localparam logic [7:0] MRD_PART_ADDR = 8'h48;

  // Reading channels, index order matches the base table
  localparam int MRD_NUM_READINGS = 4;
  localparam logic [3:0][7:0] MRD_READING_BASE = {
    MRD_DMINUS_ADDR, MRD_DPLUS_ADDR, MRD_DIE_ADDR, MRD_THERM_ADDR};

  // Field positions
  localparam int MRD_POS_DRV_LSB = 5;
  localparam int MRD_NEG_DRV_LSB = 2;
  localparam int MRD_PART_LSB = 3;
  localparam int MRD_REV_LSB = 0;

  // Reset values
  localparam logic [15:0] MRD_READING_RST = 16'h0000;
  localparam logic [7:0] MRD_DRIVE_RST = 8'h00;
  localparam logic [7:0] MRD_RDATA_RST = 8'h00;
  localparam logic [1:0] MRD_PART_RSVD = 2'h0;

  // Line drive codes
  typedef enum logic [2:0] {
    MRD_DRV_HIZ = 3'h0,
    MRD_DRV_0V0 = 3'h1,
    MRD_DRV_0V6 = 3'h2,
    MRD_DRV_1V2 = 3'h3,
    MRD_DRV_2V0 = 3'h4,
    MRD_DRV_2V7 = 3'h5,
    MRD_DRV_3V3 = 3'h6,
    MRD_DRV_SHORT = 3'h7
  } mrd_drive_t;

endpackage

// ==== rtl/mrd_reading_hold.sv ====
`timescale 1ns/1ps
`default_nettype none

module mrd_reading_hold (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic sample_valid,
  input wire logic [15:0] sample_value,
  input wire logic snap,
  output logic [15:0] value_q,
  output logic [7:0] low_snap_q
);
  import mrd_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Reading store, only the converter side loads it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      value_q <= MRD_READING_RST;
    end else if (ce && sample_valid) begin
      value_q <= sample_value; // RQ9
    end
  end

  // Low byte frozen when the high byte is read
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      low_snap_q <= MRD_READING_RST[7:0];
    end else if (ce && snap) begin
      low_snap_q <= value_q[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  hold_stable_a: assert property (@(posedge ref_clk) disable iff (rst)
    !(ce && sample_valid) |=> value_q == $past(value_q)) // RQ9
    else $error("reading changed without a sample");

  snap_take_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && snap) |=> low_snap_q == $past(value_q[7:0]))
    else $error("low byte snapshot not taken");

endmodule // mrd_reading_hold

`default_nettype wire

// ==== rtl/mrd_regs.sv ====
// How it works
// (RQ1) Thermistor ratio read-only 16-bit reading
// (RQ2) Die temperature read-only signed 16-bit reading
// (RQ3) D+ voltage read-only 16-bit reading
// (RQ4) D- voltage read-only 16-bit reading
// (RQ5) Bits 7-5 select D+ drive, reset zero
// (RQ6) Bits 4-2 select D- drive, reset zero
// (RQ7) Part code read-only in bits 5-3
// (RQ8) Revision in bits 2-0, 7-6 zero
// (RQ9) Writes to read-only registers are ignored
`timescale 1ns/1ps
`default_nettype none

module mrd_regs #(
  parameter logic [2:0] PART_CODE = 3'h5, // Arbitrary value
  parameter logic [2:0] SILICON_REV = 3'h2 // Arbitrary value
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [15:0] thermistor_ratio_value,
  input wire logic thermistor_ratio_valid,
  input wire logic [15:0] die_temp_value,
  input wire logic die_temp_valid,
  input wire logic [15:0] pos_line_voltage_value,
  input wire logic pos_line_voltage_valid,
  input wire logic [15:0] neg_line_voltage_value,
  input wire logic neg_line_voltage_valid,
  output mrd_pkg::mrd_drive_t pos_line_drive_level,
  output mrd_pkg::mrd_drive_t neg_line_drive_level,
  output logic line_short_en
);
  import mrd_pkg::*;

  logic [7:0] drive_q;
  logic [7:0] drive_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [15:0] smp_val [MRD_NUM_READINGS];
  logic smp_vld [MRD_NUM_READINGS];
  logic [15:0] rd_val [MRD_NUM_READINGS];
  logic [7:0] snap_lo [MRD_NUM_READINGS];
  logic hi_hit [MRD_NUM_READINGS];
  logic lo_hit [MRD_NUM_READINGS];
  logic drive_hit;
  logic part_hit;
  logic drive_wr;
  logic [7:0] part_byte;

  ////////////////////////////////////////////////////////////////////////
  // Converter inputs gathered by channel
  assign smp_val[0] = thermistor_ratio_value; // RQ1
  assign smp_vld[0] = thermistor_ratio_valid;
  assign smp_val[1] = die_temp_value; // RQ2
  assign smp_vld[1] = die_temp_valid;
  assign smp_val[2] = pos_line_voltage_value; // RQ3
  assign smp_vld[2] = pos_line_voltage_valid;
  assign smp_val[3] = neg_line_voltage_value; // RQ4
  assign smp_vld[3] = neg_line_voltage_valid;

  // One holder per reading, no host write path
  for (genvar i = 0; i < MRD_NUM_READINGS; i++) begin : g_rdg
    assign hi_hit[i] = (reg_addr == MRD_READING_BASE[i]);
    assign lo_hit[i] = (reg_addr == MRD_READING_BASE[i] + 8'h01);
    mrd_reading_hold u_hold (
      .ref_clk(ref_clk),
      .rst(rst),
      .ce(ce),
      .sample_valid(smp_vld[i]),
      .sample_value(smp_val[i]),
      .snap(reg_rd && hi_hit[i]),
      .value_q(rd_val[i]),
      .low_snap_q(snap_lo[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Address decode for the byte registers
  assign drive_hit = (reg_addr == MRD_DRIVE_ADDR);
  assign part_hit = (reg_addr == MRD_PART_ADDR);
  assign drive_wr = reg_wr && drive_hit; // RQ9
  assign drive_d = drive_wr ? reg_wdata : drive_q;

  // Identification byte, top bits zero
  assign part_byte = {MRD_PART_RSVD, PART_CODE, SILICON_REV}; // RQ7 RQ8

  // Read data select, unmapped reads as zero
  assign rdata_d =
    hi_hit[0] ? rd_val[0][15:8] :
    lo_hit[0] ? snap_lo[0] :
    hi_hit[1] ? rd_val[1][15:8] :
    lo_hit[1] ? snap_lo[1] :
    hi_hit[2] ? rd_val[2][15:8] :
    lo_hit[2] ? snap_lo[2] :
    hi_hit[3] ? rd_val[3][15:8] :
    lo_hit[3] ? snap_lo[3] :
    drive_hit ? drive_q :
    part_hit ? part_byte : 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // Drive select register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      drive_q <= MRD_DRIVE_RST; // RQ5 RQ6
    end else if (ce) begin
      drive_q <= drive_d;
    end
  end

  // Read data register, loaded on a read
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_q <= MRD_RDATA_RST;
    end else if (ce && reg_rd) begin
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Drive level outputs
  assign pos_line_drive_level = mrd_drive_t'(drive_q[MRD_POS_DRV_LSB +: 3]); // RQ5
  assign neg_line_drive_level = mrd_drive_t'(drive_q[MRD_NEG_DRV_LSB +: 3]); // RQ6
  assign line_short_en = (pos_line_drive_level == MRD_DRV_SHORT); // RQ5
  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence drive_write_s;
    ce && reg_wr && drive_hit;
  endsequence

  sequence drive_readback_s;
    drive_write_s ##1 (ce && reg_rd && drive_hit && !reg_wr);
  endsequence

  pos_drive_set_a: assert property (drive_write_s |=> // RQ5
    pos_line_drive_level == $past(reg_wdata[7:5]))
    else $error("D+ drive level not taken from write");

  neg_drive_set_a: assert property (drive_write_s |=> // RQ6
    neg_line_drive_level == $past(reg_wdata[4:2]))
    else $error("D- drive level not taken from write");

  drive_readback_a: assert property (drive_readback_s |=> // RQ6
    reg_rdata == $past(reg_wdata, 2))
    else $error("drive register read back wrong");

  drive_reset_a: assert property (@(posedge ref_clk) disable iff (1'b0) // RQ5
    $past(rst) |-> (drive_q == 8'h00 && !line_short_en))
    else $error("drive select not cleared by reset");

  short_flag_a: assert property (drive_write_s |=> // RQ5
    line_short_en == ($past(reg_wdata[7:5]) == 3'h7))
    else $error("short enable disagrees with D+ code");

  part_read_a: assert property ((ce && reg_rd && part_hit) |=> // RQ7
    reg_rdata[7:3] == {2'h0, PART_CODE})
    else $error("part code read wrong");

  rev_read_a: assert property ((ce && reg_rd && part_hit) |=> // RQ8
    reg_rdata[2:0] == SILICON_REV)
    else $error("silicon revision read wrong");

  therm_read_a: assert property ((ce && reg_rd && hi_hit[0]) |=> // RQ1
    reg_rdata == $past(rd_val[0][15:8]))
    else $error("thermistor high byte read wrong");

  die_pair_a: assert property ((ce && reg_rd && hi_hit[1]) ##1 // RQ2
    (ce && reg_rd && lo_hit[1]) |=> reg_rdata == $past(rd_val[1][7:0], 2))
    else $error("die temperature low byte not coherent");

  dplus_read_a: assert property ((ce && reg_rd && hi_hit[2]) |=> // RQ3
    reg_rdata == $past(rd_val[2][15:8]))
    else $error("D+ reading high byte read wrong");

  dminus_read_a: assert property ((ce && reg_rd && lo_hit[3]) |=> // RQ4
    reg_rdata == $past(snap_lo[3]))
    else $error("D- reading low byte read wrong");

  ro_write_a: assert property ((ce && reg_wr && !drive_hit) |=> // RQ9
    drive_q == $past(drive_q))
    else $error("write to read-only address changed drive select");

  freeze_a: assert property (!ce |=> (drive_q == $past(drive_q) &&
    reg_rdata == $past(reg_rdata)))
    else $error("state moved while clock enable low");

endmodule // mrd_regs

`default_nettype wire

// ==== testbench/mrd_conv_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module mrd_conv_model (
  input wire logic ref_clk,
  input wire logic load,
  input wire logic [63:0] vals,
  output logic [63:0] vout,
  output logic vld
);
  // Lines start at zero; valid stays low until the first result
  initial begin
    vout = 64'h0;
    vld = 1'b0;
  end

  // One-cycle result pulse; value lines scramble outside it
  always @(posedge ref_clk) begin
    vld <= load;
    vout <= load ? vals : ~vout;
  end
endmodule // mrd_conv_model

`default_nettype wire

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import mrd_pkg::*;
  logic ref_clk, rst, ce, reg_wr, reg_rd, load, vld, short_en;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
  logic [63:0] vals, vout;
  logic [15:0] w;
  mrd_drive_t pos_lvl, neg_lvl;
  int err_total, num_checks;

  // Clock at 100 MHz
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  mrd_conv_model conv (.ref_clk(ref_clk), .load(load), .vals(vals), .vout(vout), .vld(vld));

  mrd_regs #(.PART_CODE(3'h3), .SILICON_REV(3'h6)) DUT (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .thermistor_ratio_value(vout[15:0]), .thermistor_ratio_valid(vld),
    .die_temp_value(vout[31:16]), .die_temp_valid(vld),
    .pos_line_voltage_value(vout[47:32]), .pos_line_voltage_valid(vld),
    .neg_line_voltage_value(vout[63:48]), .neg_line_voltage_valid(vld),
    .pos_line_drive_level(pos_lvl), .neg_line_drive_level(neg_lvl),
    .line_short_en(short_en));

  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Register write, taken at the second edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // Register read, data settled just after the taken edge
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // Word read, high byte then low byte in back-to-back cycles
  task automatic rd_word(input logic [7:0] a, input logic bump, output logic [15:0] w);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    load <= bump;
    @(posedge ref_clk);
    reg_addr <= a + 8'h01;
    load <= 1'b0;
    @(negedge ref_clk);
    w[15:8] = reg_rdata;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    w[7:0] = reg_rdata;
  endtask

  // Verdict
  task automatic wrap_up();
    if (err_total == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (3000) @(posedge ref_clk);
    err_total++;
    wrap_up();
  end

  // Main sequence
  initial begin
    int i;
    err_total = 0;
    num_checks = 0;
    rst = 1'b1;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    load = 1'b0;
    vals = 64'h0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    // Reset contents, readings and drive select
    for (i = 8'h3f; i < 8'h48; i++) begin
      rd(i[7:0]);
      chk(v, 16'h0000);
    end
    rd(MRD_PART_ADDR);
    chk(v, 16'h001e);
    // Boundary results, word read high then low
    @(posedge ref_clk);
    vals <= {16'h0001, 16'h0e10, 16'hffb0, 16'h03ff};
    load <= 1'b1;
    @(posedge ref_clk);
    load <= 1'b0;
    repeat (3) @(posedge ref_clk);
    for (i = 0; i < 4; i++) begin
      rd(MRD_READING_BASE[i]);
      chk(v, vals[i*16+8+:8]);
      rd(MRD_READING_BASE[i] + 8'h01);
      chk(v, vals[i*16+:8]);
    end
    // Writes to read-only places leave them alone
    wr(MRD_THERM_ADDR, 8'hff);
    wr(MRD_PART_ADDR, 8'hff);
    rd(MRD_THERM_ADDR);
    chk(v, vals[15:8]);
    rd(MRD_PART_ADDR);
    chk(v, 16'h001e);
    // Every drive code on both lines
    for (i = 0; i < 8; i++) begin
      wr(MRD_DRIVE_ADDR, {i[2:0], i[2:0], 2'h1});
      #1;
      chk(pos_lvl, i[2:0]);
      chk(neg_lvl, i[2:0]);
      chk(short_en, i == 7);
      rd(MRD_DRIVE_ADDR);
      chk(v, {i[2:0], i[2:0], 2'h1});
    end
    // Write then read back to back; read with write returns the old byte
    @(posedge ref_clk);
    reg_addr <= MRD_DRIVE_ADDR;
    reg_wdata <= 8'ha6;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_wdata <= 8'h5b;
    reg_wr <= 1'b1;
    @(negedge ref_clk);
    chk(reg_rdata, 8'ha6);
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk(reg_rdata, 8'ha6);
    chk(pos_lvl, 3'h2);
    chk(neg_lvl, 3'h6);
    // Clock enable low freezes strobes and converter loads
    @(posedge ref_clk);
    ce <= 1'b0;
    reg_wdata <= 8'h00;
    reg_wr <= 1'b1;
    reg_rd <= 1'b1;
    vals <= 64'h1234_5678_9abc_def0;
    load <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    load <= 1'b0;
    @(posedge ref_clk);
    ce <= 1'b1;
    @(negedge ref_clk);
    chk(reg_rdata, 8'ha6);
    chk(pos_lvl, 3'h2);
    rd(MRD_THERM_ADDR);
    chk(v, 16'h0003);
    // Coherent word with a new result between the byte reads
    rd_word(MRD_DIE_ADDR, 1'b1, w);
    chk(w, 16'hffb0);
    rd_word(MRD_DIE_ADDR, 1'b0, w);
    chk(w, vals[31:16]);
    // Reset in mid-run clears drive select and readings
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd(MRD_DRIVE_ADDR);
    chk(v, 16'h0000);
    chk(pos_lvl, 3'h0);
    rd_word(MRD_DPLUS_ADDR, 1'b0, w);
    chk(w, 16'h0000);
    // Unmapped address reads as zero
    rd(8'h50);
    chk(v, 16'h0000);
    wrap_up();
  end
endmodule // tb_top

`default_nettype wire
